// File: core/mnp_defines.svh
// constants for the melody note player: addresses, sizes, timing counts
`ifndef MNP_DEFINES_SVH
`define MNP_DEFINES_SVH

`define MNP_DEV_ADDR 7'h3c
`define MNP_MELODY_REG 8'hf0
`define MNP_STOP_CODE 8'hff
`define MNP_FIFO_DEPTH 4'ha
`define MNP_FIFO_LAST 4'h9
`define MNP_REG_DEPTH 16
`define MNP_NOTE_COUNT 8'h3c
`define MNP_CLK_HZ 25000000
`define MNP_UNIT_MS 4
`define MNP_UNIT_CYC (`MNP_CLK_HZ / 1000 * `MNP_UNIT_MS)
`define MNP_TONE_REF_HZ 500000
`define MNP_HALF_CYC (`MNP_CLK_HZ / (2 * `MNP_TONE_REF_HZ))

`endif

// File: core/mnp_pkg.sv
// types shared by the melody note player
package mnp_pkg;

  typedef enum logic [6:0] {
    I2C_IDLE = 7'h01,
    I2C_ADDR = 7'h02,
    I2C_ADDR_ACK = 7'h04,
    I2C_WR_BYTE = 7'h08,
    I2C_WR_ACK = 7'h10,
    I2C_RD_BYTE = 7'h20,
    I2C_RD_ACK = 7'h40
  } mnp_i2c_state_type;

  typedef enum logic [4:0] {
    PL_IDLE = 5'h01,
    PL_LOAD = 5'h02,
    PL_SOUND = 5'h04,
    PL_HOLD = 5'h08,
    PL_REST = 5'h10
  } mnp_play_state_type;

  typedef struct packed {
    logic [7:0] note_index;
    logic [7:0] timing_a;
    logic [7:0] timing_b;
    logic [7:0] timing_c;
  } mnp_note_type;

endpackage

// File: core/mnp_mem.sv
// small memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module mnp_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store [DEPTH];

  // array itself has no reset, so it maps onto plain ram
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  // read data from a register; a write lands one edge before it can be read back
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= store[rd_addr];
    end
  end
endmodule // mnp_mem
`default_nettype wire

// File: core/mnp_player.sv
// i2c slave with note fifo, register space and tone generator
`timescale 1ns/1ps
`default_nettype none
`include "mnp_defines.svh"
module mnp_player #(
  parameter int unsigned UNIT_CYCLES = `MNP_UNIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic tone_out,
  output logic playing
);
  // index 59 sits at the top, index 0 at the bottom
  localparam logic [719:0] DIV_TABLE = {
    12'h04b, 12'h050, 12'h054, 12'h059, 12'h05f, 12'h064, 12'h06a, 12'h071, 12'h077, 12'h07f,
    12'h086, 12'h08e, 12'h096, 12'h09f, 12'h0a9, 12'h0b3, 12'h0be, 12'h0c9, 12'h0d5, 12'h0e1,
    12'h0ef, 12'h0fd, 12'h10c, 12'h11c, 12'h12d, 12'h13f, 12'h152, 12'h166, 12'h17b, 12'h192,
    12'h1aa, 12'h1c3, 12'h1de, 12'h1fa, 12'h218, 12'h238, 12'h25a, 12'h27e, 12'h2a4, 12'h2cc,
    12'h2f6, 12'h324, 12'h353, 12'h386, 12'h3bc, 12'h3f4, 12'h431, 12'h470, 12'h4b4, 12'h4fc,
    12'h547, 12'h598, 12'h5ed, 12'h647, 12'h6a7, 12'h70c, 12'h777, 12'h7e9, 12'h861, 12'h8e1};

  logic [1:0] sync1, sync2, sync3, pin_q, pin_prev;
  logic scl_rise, scl_fall, start_c, stop_c;
  mnp_pkg::mnp_i2c_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_byte, tx_byte, tx_src, ptr;
  logic rd_mode, first_byte, first_data;
  logic byte_done, mel_wr, reg_wr, flush, push, pop, tx_load;
  logic [1:0] asm_pos;
  logic [23:0] asm_data;
  logic [3:0] wr_ptr, rd_ptr, fifo_count;
  logic [7:0] reg_rdata;
  mnp_pkg::mnp_note_type fifo_rdata, cur;
  mnp_pkg::mnp_play_state_type p_state;
  logic [7:0] ph_left;
  logic [16:0] unit_cnt;
  logic unit_tick, unit_restart;
  logic [4:0] half_cnt;
  logic half_tick, sounding;
  logic [11:0] tone_cnt, div;
  logic [9:0] div_base;

  function automatic logic [3:0] wrap_inc(input logic [3:0] p);
    wrap_inc = (p == `MNP_FIFO_LAST) ? 4'h0 : p + 4'h1;
  endfunction

  // three-stage pin sync; a level counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
      sync3 <= 2'h3;
      pin_q <= 2'h3;
      pin_prev <= 2'h3;
    end else begin
      sync1 <= {scl_in, sda_in};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_q <= (sync2 & sync3) | (pin_q & (sync2 ^ sync3));
      pin_prev <= pin_q;
    end
  end

  // bus events; start and stop need scl high across the sda edge
  assign scl_rise = pin_q[1] & ~pin_prev[1];
  assign scl_fall = ~pin_q[1] & pin_prev[1];
  assign start_c = pin_q[1] & pin_prev[1] & pin_prev[0] & ~pin_q[0];
  assign stop_c = pin_q[1] & pin_prev[1] & ~pin_prev[0] & pin_q[0];

  // byte strobes for the pointer, register and melody paths
  assign byte_done = (state == mnp_pkg::I2C_WR_BYTE) && scl_fall && (bit_cnt == 4'h8);
  assign mel_wr = byte_done && !first_byte && (ptr == `MNP_MELODY_REG);
  assign reg_wr = byte_done && !first_byte && (ptr != `MNP_MELODY_REG);
  assign flush = mel_wr && first_data && (asm_pos == 2'h0) &&
                 (rx_byte == `MNP_STOP_CODE);
  assign push = mel_wr && !flush && (asm_pos == 2'h3) &&
                (fifo_count != `MNP_FIFO_DEPTH);
  assign tx_load = (state == mnp_pkg::I2C_ADDR_ACK) && scl_fall && rd_mode;
  // melody register reads back the fill level, unmapped ones read zero
  assign tx_src = (ptr == `MNP_MELODY_REG) ? {4'h0, fifo_count} :
                  ((ptr < `MNP_REG_DEPTH) ? reg_rdata : 8'h00);

  // receive shifter, sampled on scl rising
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_byte <= 8'h00;
    end else if (scl_rise && (state == mnp_pkg::I2C_ADDR || state == mnp_pkg::I2C_WR_BYTE)) begin
      rx_byte <= {rx_byte[6:0], pin_q[0]};
    end
  end

  // protocol sequencer; sda only changes after scl falls
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= mnp_pkg::I2C_IDLE;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
      rd_mode <= 1'b0;
      tx_byte <= 8'h00;
    end else if (start_c) begin
      state <= mnp_pkg::I2C_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      state <= mnp_pkg::I2C_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        mnp_pkg::I2C_ADDR: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (rx_byte[7:1] == `MNP_DEV_ADDR) begin
              sda_oe <= 1'b1;
              rd_mode <= rx_byte[0];
              state <= mnp_pkg::I2C_ADDR_ACK;
            end else begin
              state <= mnp_pkg::I2C_IDLE;
            end
          end
        end
        mnp_pkg::I2C_ADDR_ACK: begin
          if (scl_fall) begin
            if (rd_mode) begin
              tx_byte <= tx_src;
              sda_oe <= ~tx_src[7];
              bit_cnt <= 4'h1;
              state <= mnp_pkg::I2C_RD_BYTE;
            end else begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              state <= mnp_pkg::I2C_WR_BYTE;
            end
          end
        end
        mnp_pkg::I2C_WR_BYTE: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            sda_oe <= 1'b1;
            state <= mnp_pkg::I2C_WR_ACK;
          end
        end
        mnp_pkg::I2C_WR_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            state <= mnp_pkg::I2C_WR_BYTE;
          end
        end
        mnp_pkg::I2C_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state <= mnp_pkg::I2C_RD_ACK;
            end else begin
              sda_oe <= ~tx_byte[3'(4'h7 - bit_cnt)];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        // only one byte per read; later clocks see a released line
        mnp_pkg::I2C_RD_ACK: begin
          if (scl_rise) begin
            state <= mnp_pkg::I2C_IDLE;
          end
        end
        default: begin
          state <= mnp_pkg::I2C_IDLE;
        end
      endcase
    end
  end

  // open drain: the pad only ever pulls low
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // register pointer with auto-increment; the melody register does not advance
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr <= 8'h00;
      first_byte <= 1'b0;
      first_data <= 1'b0;
    end else if (state == mnp_pkg::I2C_ADDR_ACK && scl_fall && !rd_mode) begin
      first_byte <= 1'b1;
    end else if (byte_done) begin
      first_byte <= 1'b0;
      first_data <= first_byte;
      if (first_byte) begin
        ptr <= rx_byte;
      end else if (reg_wr) begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  // entry assembly; start or stop throws away an unfinished entry
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      asm_pos <= 2'h0;
      asm_data <= 24'h000000;
    end else if (start_c || stop_c || flush) begin
      asm_pos <= 2'h0;
    end else if (mel_wr) begin
      asm_data <= {asm_data[15:0], rx_byte};
      asm_pos <= asm_pos + 2'h1;
    end
  end

  // fifo pointers; a full fifo drops further entries, flush wins over all
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      fifo_count <= 4'h0;
    end else if (flush) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      fifo_count <= 4'h0;
    end else begin
      if (push) begin
        wr_ptr <= wrap_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= wrap_inc(rd_ptr);
      end
      if (push && !pop) begin
        fifo_count <= fifo_count + 4'h1;
      end else if (pop && !push) begin
        fifo_count <= fifo_count - 4'h1;
      end
    end
  end

  mnp_mem #(.WIDTH(32), .DEPTH(10), .AW(4)) u_note_mem (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(push),
    .wr_addr(wr_ptr),
    .wr_data({asm_data, rx_byte}),
    .rd_addr(rd_ptr),
    .rd_data(fifo_rdata)
  );

  mnp_mem #(.WIDTH(8), .DEPTH(`MNP_REG_DEPTH), .AW(4)) u_reg_mem (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(reg_wr && (ptr < `MNP_REG_DEPTH)),
    .wr_addr(ptr[3:0]),
    .wr_data(rx_byte),
    .rd_addr(ptr[3:0]),
    .rd_data(reg_rdata)
  );

  // 4 ms unit timer, restarted per phase so each phase is whole units
  assign unit_tick = (unit_cnt == 17'(UNIT_CYCLES - 1));
  assign unit_restart = (p_state == mnp_pkg::PL_IDLE) || (p_state == mnp_pkg::PL_LOAD) ||
                        (ph_left == 8'h00);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      unit_cnt <= 17'h00000;
    end else if (unit_restart || unit_tick) begin
      unit_cnt <= 17'h00000;
    end else begin
      unit_cnt <= unit_cnt + 17'h00001;
    end
  end

  // note sequencer: sound for timing_a and timing_b, rest for timing_c, then pop
  assign pop = (p_state == mnp_pkg::PL_REST) && (ph_left == 8'h00) && !flush;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      p_state <= mnp_pkg::PL_IDLE;
      cur <= '0;
      ph_left <= 8'h00;
      playing <= 1'b0;
    end else begin
      playing <= !flush && (p_state != mnp_pkg::PL_IDLE);
      if (flush) begin
        p_state <= mnp_pkg::PL_IDLE;
        ph_left <= 8'h00;
      end else begin
        case (p_state)
          mnp_pkg::PL_IDLE: begin
            if (fifo_count != 4'h0) begin
              p_state <= mnp_pkg::PL_LOAD;
            end
          end
          mnp_pkg::PL_LOAD: begin
            cur <= fifo_rdata;
            ph_left <= fifo_rdata.timing_a;
            p_state <= mnp_pkg::PL_SOUND;
          end
          mnp_pkg::PL_SOUND: begin
            if (ph_left == 8'h00) begin
              ph_left <= cur.timing_b;
              p_state <= mnp_pkg::PL_HOLD;
            end else if (unit_tick) begin
              ph_left <= ph_left - 8'h01;
            end
          end
          mnp_pkg::PL_HOLD: begin
            if (ph_left == 8'h00) begin
              ph_left <= cur.timing_c;
              p_state <= mnp_pkg::PL_REST;
            end else if (unit_tick) begin
              ph_left <= ph_left - 8'h01;
            end
          end
          mnp_pkg::PL_REST: begin
            if (ph_left == 8'h00) begin
              p_state <= mnp_pkg::PL_IDLE;
            end else if (unit_tick) begin
              ph_left <= ph_left - 8'h01;
            end
          end
          default: begin
            p_state <= mnp_pkg::PL_IDLE;
          end
        endcase
      end
    end
  end

  // divisor lookup; indices past the table play as a rest
  assign div_base = 10'(cur.note_index[5:0]) * 10'h00c;
  assign div = (cur.note_index < `MNP_NOTE_COUNT) ? DIV_TABLE[div_base +: 12] : 12'h000;
  assign sounding = (p_state == mnp_pkg::PL_SOUND || p_state == mnp_pkg::PL_HOLD) &&
                    (div != 12'h000);
  assign half_tick = (half_cnt == 5'(`MNP_HALF_CYC - 1));

  // ticks at twice the reference, so a full tone period is divisor reference cycles
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_cnt <= 5'h00;
    end else begin
      half_cnt <= half_tick ? 5'h00 : half_cnt + 5'h01;
    end
  end

  // tone toggle; silent whenever no note is sounding
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tone_cnt <= 12'h000;
      tone_out <= 1'b0;
    end else if (!sounding || flush) begin
      tone_cnt <= 12'h000;
      tone_out <= 1'b0;
    end else if (half_tick) begin
      if (tone_cnt >= div - 12'h001) begin
        tone_cnt <= 12'h000;
        tone_out <= ~tone_out;
      end else begin
        tone_cnt <= tone_cnt + 12'h001;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_FIFO_BOUND: assert property (fifo_count <= `MNP_FIFO_DEPTH)
    else $error("note fifo holds more than ten entries");
  AST_PUSH_FOURTH: assert property (push && !pop |=> asm_pos == 2'h0 &&
    fifo_count == $past(fifo_count) + 4'h1)
    else $error("entry push did not add one whole entry");
  AST_FLUSH_EMPTY: assert property (
    flush |=> fifo_count == 4'h0 && !playing && !tone_out)
    else $error("stop code did not empty fifo and silence tone");
  AST_READ_COUNT: assert property (tx_load && ptr == `MNP_MELODY_REG |=>
    tx_byte == {4'h0, $past(fifo_count)})
    else $error("melody read did not return fifo fill level");
  AST_DIV_A3: assert property (cur.note_index == 8'h00 |-> div == 12'h8e1)
    else $error("index zero does not map to its divisor");
  AST_DIV_A4: assert property (cur.note_index == 8'h0c |-> div == 12'h470)
    else $error("index twelve does not map to 440 Hz divisor");
  AST_UNIT_HOLD: assert property (p_state == mnp_pkg::PL_SOUND && ph_left != 8'h00 &&
    !unit_tick && !flush |=> ph_left == $past(ph_left))
    else $error("timing count moved without a unit tick");
  AST_AUTO_INC: assert property (reg_wr |=> ptr == $past(ptr) + 8'h01)
    else $error("register pointer did not advance after a data byte");
  AST_ONE_BYTE: assert property (state == mnp_pkg::I2C_RD_ACK && scl_rise &&
    !start_c && !stop_c |=> state == mnp_pkg::I2C_IDLE)
    else $error("read went past one byte");
  AST_TONE_STEP: assert property (!flush && sounding && $past(sounding) &&
    tone_out != $past(tone_out) |-> $past(half_tick))
    else $error("tone toggled off the reference tick");
  AST_POP_ORDER: assert property (pop && !push |=> rd_ptr == wrap_inc($past(rd_ptr)) &&
    fifo_count == $past(fifo_count) - 4'h1)
    else $error("finished note not removed in order");

  COV_PUSH: cover property (push);
  COV_FLUSH: cover property (flush && fifo_count != 4'h0);
  COV_READ_COUNT: cover property (tx_load && ptr == `MNP_MELODY_REG);
  COV_POP: cover property (pop ##1 p_state == mnp_pkg::PL_IDLE ##1 p_state == mnp_pkg::PL_LOAD);
endmodule // mnp_player
`default_nettype wire

// File: test/mnp_host_model.sv
// host-side i2c master model: drives the bus clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module mnp_host_model #(
  parameter int HALF = 8
) (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // bus idle at time zero: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one third of a bit; long enough for the device's synchroniser and filter
  task automatic hw();
    repeat (HALF) @(posedge core_clk);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    @(posedge core_clk);
    sda_low <= 1'b0;
    hw();
    scl <= 1'b1;
    hw();
    sda_low <= 1'b1;
    hw();
    scl <= 1'b0;
    hw();
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    sda_low <= 1'b1;
    hw();
    scl <= 1'b1;
    hw();
    sda_low <= 1'b0;
    hw();
  endtask

  // data changes only a third of a bit after the clock fell, so it never mimics a start
  task automatic xbit(input logic b, output logic r);
    sda_low <= ~b;
    hw();
    scl <= 1'b1;
    hw();
    r = sda;
    scl <= 1'b0;
    hw();
  endtask

  // byte sent msb first, then the ninth clock reads the device's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask

  // a single byte is read, then not acknowledged: no multi-byte reads
  task automatic rd_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(1'b1, r);
  endtask
endmodule // mnp_host_model
`default_nettype wire

// File: test/mnp_player_tb_top.sv
// self-checking testbench for the melody note player
`timescale 1ns/1ps
`default_nettype none
`include "mnp_defines.svh"
module mnp_player_tb_top;
  localparam int UNIT = 20;
  logic core_clk;
  logic rst_b;
  logic scl;
  logic host_low;
  wire logic sda;
  logic sda_out;
  logic sda_oe;
  logic tone_out;
  logic playing;
  int num_errors;
  int num_checks;

  // open-drain line with pull-up: low while either side pulls
  assign sda = !((sda_oe && !sda_out) || host_low);

  mnp_player #(.UNIT_CYCLES(UNIT)) i_dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .tone_out(tone_out),
    .playing(playing)
  );

  mnp_host_model i_host (
    .core_clk(core_clk),
    .sda(sda),
    .scl(scl),
    .sda_low(host_low)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one write transfer to the device, every byte expected to be acknowledged
  task automatic host_wr(input logic [7:0] b[$]);
    logic ack;
    i_host.start();
    i_host.wr_byte(8'h78, ack);
    check("write address ack", ack, 1'b1);
    foreach (b[i]) begin
      i_host.wr_byte(b[i], ack);
      check("data ack", ack, 1'b1);
    end
    i_host.stop();
  endtask

  // pointer write, then a one-byte read at the read address
  task automatic host_rd(input logic [7:0] ptr, output logic [7:0] d);
    logic ack;
    host_wr('{ptr});
    i_host.start();
    i_host.wr_byte(8'h79, ack);
    check("read address ack", ack, 1'b1);
    i_host.rd_byte(d);
    i_host.stop();
  endtask

  // burst write with auto-increment, read-back, and a foreign address
  task automatic t_regs();
    logic [7:0] d;
    logic ack;
    host_wr('{8'h06, 8'h0a, 8'h3c});
    host_rd(8'h06, d);
    check("reg 06", d, 8'h0a);
    host_rd(8'h07, d);
    check("reg 07", d, 8'h3c);
    host_rd(8'h20, d);
    check("unmapped reg", d, 8'h00);
    i_host.start();
    i_host.wr_byte(8'h7a, ack);
    i_host.stop();
    check("foreign address ack", ack, 1'b0);
    $display("t_regs done");
  endtask

  // queue, overfill and flush; long notes keep the first one playing throughout
  task automatic t_fifo();
    logic [7:0] q[$];
    logic [7:0] d;
    q = '{`MNP_MELODY_REG};
    repeat (3) q = {q, 8'h0c, 8'hff, 8'hff, 8'hff};
    q = {q, 8'h0c, 8'h01};
    host_wr(q);
    host_rd(`MNP_MELODY_REG, d);
    check("count after three", d, 8'h03);
    check("playing", playing, 1'b1);
    q = '{`MNP_MELODY_REG};
    repeat (8) q = {q, 8'h0c, 8'hff, 8'hff, 8'hff};
    host_wr(q);
    host_rd(`MNP_MELODY_REG, d);
    check("count when full", d, 8'h0a);
    host_wr('{`MNP_MELODY_REG, 8'hff});
    repeat (4) @(negedge core_clk);
    check("playing after stop", playing, 1'b0);
    check("tone after stop", tone_out, 1'b0);
    host_rd(`MNP_MELODY_REG, d);
    check("count after stop", d, 8'h00);
    $display("t_fifo done");
  endtask

  // highest note: its short divisor gives several half periods inside one note
  task automatic t_tone();
    logic [7:0] d;
    logic prev;
    int t;
    int e;
    int last;
    int per;
    int dur;
    host_wr('{`MNP_MELODY_REG, 8'h3b, 8'hff, 8'hff, 8'h10});
    t = 0;
    e = 0;
    last = 0;
    per = 0;
    prev = tone_out;
    // sampled on the falling edge, where registered outputs have settled
    while (playing === 1'b1 && t < 20000) begin
      @(negedge core_clk);
      t++;
      if (tone_out !== prev) begin
        e++;
        if (e == 2) per = t - last;
        last = t;
      end
      prev = tone_out;
    end
    check("half period", (per >= 1873 && per <= 1877), 1'b1);
    check("tone edges", (e >= 4), 1'b1);
    // host_wr returns shortly after the push, so the note started a few dozen cycles earlier
    dur = (255 + 255 + 16) * UNIT;
    check("note length", (t >= dur - 100 && t <= dur + 20), 1'b1);
    check("silent in rest", (t - last >= 16 * UNIT - 2), 1'b1);
    check("tone when empty", tone_out, 1'b0);
    host_rd(`MNP_MELODY_REG, d);
    check("count after note", d, 8'h00);
    $display("t_tone done");
  endtask

  // cycles from one tone edge to the next, after first waiting for an edge
  task automatic tone_gap(output int per);
    logic prev;
    int t;
    t = 0;
    prev = tone_out;
    while (tone_out === prev && t < 8000) begin
      @(negedge core_clk);
      t++;
    end
    prev = tone_out;
    per = 0;
    while (tone_out === prev && per < 8000) begin
      @(negedge core_clk);
      per++;
    end
  endtask

  // two notes back to back must sound in arrival order; half period is divisor times 25 cycles
  task automatic t_order();
    logic [7:0] d;
    int per;
    int t;
    host_wr('{`MNP_MELODY_REG, 8'h3a, 8'hff, 8'h00, 8'h00, 8'h3b, 8'hff, 8'h00, 8'h00});
    tone_gap(per);
    check("first note half period", 16'(per), 16'(80 * 25));
    tone_gap(per);
    check("second note half period", 16'(per), 16'(75 * 25));
    t = 0;
    while (playing === 1'b1 && t < 8000) begin
      @(negedge core_clk);
      t++;
    end
    host_rd(`MNP_MELODY_REG, d);
    check("count after both", d, 8'h00);
    $display("t_order done");
  endtask

  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // about 45k cycles of work expected; well beyond that means a hang
  initial begin
    repeat (80000) @(posedge core_clk);
    num_errors++;
    $display("watchdog expired");
    conclude();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    num_errors = 0;
    num_checks = 0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(negedge core_clk);
    check("idle oe", sda_oe, 1'b0);
    check("idle sda out", sda_out, 1'b0);
    check("idle playing", playing, 1'b0);
    t_regs();
    t_fifo();
    t_tone();
    t_order();
    conclude();
  end
endmodule // mnp_player_tb_top
`default_nettype wire
